// ==== rtl/prg_gate.sv ====
// Reset sequencer and management access gate
// Function
// - Pin release hold-off: 4us, 300us or 200ms
// - Register reset 100 ns, same hold-off
// - Clock output is 125.00 or 156.25 MHz
// - Reference 25 or 125 MHz select is only stored; timing runs on mclk
`timescale 1ns/1ps
`default_nettype none
`include "prg_defs.svh"

module prg_gate
  import prg_pkg::*;
#(
  parameter int unsigned CYC_SRST  = `PRG_CYC_SRST,
  parameter int unsigned CYC_LONG  = `PRG_CYC_LONG,
  parameter int unsigned CYC_HWAIT = `PRG_CYC_HWAIT,
  parameter int unsigned CYC_HWLNG = `PRG_CYC_HWLNG,
  parameter int unsigned CYC_MED   = `PRG_CYC_MED,
  parameter int unsigned CYC_FAST  = `PRG_CYC_FAST
)
(
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        hard_reset_n,
  input  wire logic        soft_reset_pin_n,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic      [1:0]  avs_response,
  output logic             smi_access_ok,
  output logic             phy_core_reset,
  output logic      [31:0] clock_output_khz,
  output logic             clock_output_tick
);

  localparam int CNTW = 32;

  logic hard_s;
  logic soft_s;

  prg_sync #(.WIDTH(2), .RST_VAL(16'h0003)) u_sync
  (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .async_in ({hard_reset_n, soft_reset_pin_n}),
    .sync_out ({hard_s, soft_s})
  );

  prg_cfg_s   cfg_ff,   nxt_cfg;
  prg_state_e state_ff, nxt_state;
  prg_src_e   src_ff,   nxt_src;
  logic [CNTW-1:0] cnt_ff, nxt_cnt;
  logic [CNTW-1:0] gap_ff, nxt_gap;
  logic            viol_ff, nxt_viol;
  logic            sreg_ff, nxt_sreg;
  logic            ack_ff,  nxt_ack;
  logic [31:0]     rd_ff,   nxt_rd;
  logic [1:0]      resp_ff, nxt_resp;

  // Hold-off count for the two configuration bits after a soft reset
  function automatic logic [CNTW-1:0] soft_wait(input prg_cfg_s c);
    if (c.long_wait)
      soft_wait = CNTW'(CYC_LONG);
    else if (c.fast_restart)
      soft_wait = CNTW'(CYC_FAST);
    else
      soft_wait = CNTW'(CYC_MED);
  endfunction

  // Saturating increment so idle counters never wrap into a false short gap
  function automatic logic [CNTW-1:0] sat_inc(input logic [CNTW-1:0] v);
    sat_inc = (&v) ? v : v + CNTW'(1);
  endfunction

  logic req;
  logic wr_go;
  logic viol_set;
  logic hit_ctrl, hit_stat, hit_srst, hit_cfg;

  always_comb
  begin
    req      = (avs_read | avs_write) & ~ack_ff;
    // Writes land only at the edge that ends the ack cycle, one edge after the wait state ends
    wr_go    = avs_write & ack_ff;
    hit_ctrl = avs_address == `PRG_CTRL_OFS;
    hit_stat = avs_address == `PRG_STAT_OFS;
    hit_srst = avs_address == `PRG_SOFTRST_OFS;
    hit_cfg  = avs_address == `PRG_CFG_OFS;
  end

  // Sequencer
  always_comb
  begin
    nxt_state = state_ff;
    nxt_src   = src_ff;
    nxt_cnt   = sat_inc(cnt_ff);
    nxt_gap   = sat_inc(gap_ff);
    nxt_viol  = viol_ff;
    viol_set  = 1'b0;
    nxt_sreg  = sreg_ff;
    // Register soft reset bit is self-clearing once held long enough
    if (wr_go && hit_srst && avs_byteenable[1] && avs_writedata[15])
      nxt_sreg = 1'b1;
    if (!hard_s)
    begin
      nxt_state = PRG_HRST;
      if (state_ff != PRG_HRST)
        nxt_cnt = '0;
      nxt_src = PRG_SRC_HARD;
    end
    else
    begin
      case (state_ff)
        PRG_IDLE:
        begin
          if (!soft_s)
          begin
            // A pin pulse that returns too soon is flagged, not refused
            // Gap count is one behind the high time, hence the minus one
            if (gap_ff < CNTW'(CYC_SRST - 1) && src_ff == PRG_SRC_PIN)
              viol_set = 1'b1;
            nxt_state = PRG_SPIN;
            nxt_cnt   = '0;
            nxt_src   = PRG_SRC_PIN;
          end
          else if (sreg_ff)
          begin
            nxt_state = PRG_SREG;
            nxt_cnt   = '0;
            nxt_src   = PRG_SRC_REG;
          end
        end
        PRG_HRST:
        begin
          // Released: a too-short pulse is ignored as a glitch
          if (cnt_ff + CNTW'(1) < CNTW'(`PRG_CYC_HRST))
            nxt_state = PRG_IDLE;
          else
          begin
            nxt_state = PRG_WAIT;
            nxt_cnt   = cfg_ff.long_wait ? CNTW'(CYC_HWLNG) : CNTW'(CYC_HWAIT);
          end
        end
        PRG_SPIN:
        begin
          if (soft_s)
          begin
            if (cnt_ff < CNTW'(CYC_SRST - 1))
              viol_set = 1'b1;
            nxt_state = PRG_WAIT;
            nxt_cnt   = soft_wait(cfg_ff);
            nxt_gap   = '0;
          end
        end
        PRG_SREG:
        begin
          if (cnt_ff + CNTW'(1) >= CNTW'(`PRG_CYC_SREG))
          begin
            nxt_sreg  = 1'b0;
            nxt_state = PRG_WAIT;
            nxt_cnt   = soft_wait(cfg_ff);
          end
        end
        PRG_WAIT:
        begin
          nxt_cnt = cnt_ff - CNTW'(1);
          if (!soft_s)
          begin
            nxt_state = PRG_SPIN;
            nxt_cnt   = '0;
            nxt_src   = PRG_SRC_PIN;
            if (gap_ff < CNTW'(CYC_SRST - 1))
              viol_set = 1'b1;
          end
          else if (cnt_ff <= CNTW'(1))
            nxt_state = PRG_IDLE;
        end
        default: nxt_state = PRG_IDLE;
      endcase
    end
    // Set wins over a software clear of the violation flag
    if (viol_set)
      nxt_viol = 1'b1;
    else if (wr_go && hit_stat && avs_writedata[`PRG_STAT_VIOL_BIT])
      nxt_viol = 1'b0;
  end

  // Bus slave: one wait cycle, then ack
  always_comb
  begin
    nxt_cfg  = cfg_ff;
    nxt_ack  = req;
    nxt_rd   = 32'h0000_0000;
    nxt_resp = 2'b00;
    if (req)
    begin
      if (!(hit_ctrl || hit_stat || hit_srst || hit_cfg))
        nxt_resp = 2'b10;
      if (avs_read)
      begin
        if (hit_ctrl)
          nxt_rd = {28'h0, cfg_ff.clk_out_156, cfg_ff.ref_is_125,
                    cfg_ff.long_wait, cfg_ff.fast_restart};
        else if (hit_stat)
          nxt_rd = {27'h0, viol_ff, 1'b0, src_ff, state_ff != PRG_IDLE};
        else if (hit_srst)
          nxt_rd = {16'h0, sreg_ff, 15'h0};
        else if (hit_cfg)
          nxt_rd = cnt_ff;
      end
    end
    if (wr_go && hit_ctrl && avs_byteenable[0])
    begin
      nxt_cfg.fast_restart = avs_writedata[`PRG_CTRL_FAST_BIT];
      nxt_cfg.long_wait    = avs_writedata[`PRG_CTRL_LONG_BIT];
      nxt_cfg.ref_is_125   = avs_writedata[`PRG_CTRL_REF_BIT];
      nxt_cfg.clk_out_156  = avs_writedata[`PRG_CTRL_CLK_BIT];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      cfg_ff   <= '0;
      state_ff <= PRG_IDLE;
      src_ff   <= PRG_SRC_NONE;
      cnt_ff   <= '0;
      gap_ff   <= '1;
      viol_ff  <= 1'b0;
      sreg_ff  <= 1'b0;
      ack_ff   <= 1'b0;
      rd_ff    <= 32'h0000_0000;
      resp_ff  <= 2'b00;
    end
    else
    begin
      cfg_ff   <= nxt_cfg;
      state_ff <= nxt_state;
      src_ff   <= nxt_src;
      cnt_ff   <= nxt_cnt;
      gap_ff   <= nxt_gap;
      viol_ff  <= nxt_viol;
      sreg_ff  <= nxt_sreg;
      ack_ff   <= nxt_ack;
      rd_ff    <= nxt_rd;
      resp_ff  <= nxt_resp;
    end
  end

  assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
  assign avs_readdata    = rd_ff;
  assign avs_response    = resp_ff;
  assign smi_access_ok   = state_ff == PRG_IDLE && hard_s && soft_s;
  assign phy_core_reset  = state_ff == PRG_HRST || state_ff == PRG_SPIN
                           || state_ff == PRG_SREG;

  // Timing counts are taken on mclk, independent of which reference is used
  prg_clock_output u_clk
  (
    .mclk              (mclk),
    .reset_n           (reset_n),
    .sel_156           (cfg_ff.clk_out_156),
    .clock_output_khz  (clock_output_khz),
    .clock_output_tick (clock_output_tick)
  );

  sequence s_pin_release;
    state_ff == PRG_SPIN && nxt_state == PRG_WAIT;
  endsequence

  AST_PIN_WAIT: assert property (@(posedge mclk) disable iff (!reset_n)
    s_pin_release |=> cnt_ff == soft_wait(cfg_ff) || $changed(cfg_ff))
    else $error("pin hold-off not loaded");

  AST_SREG_HOLD: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(state_ff == PRG_SREG) |-> (state_ff == PRG_SREG || !hard_s) [*2])
    else $error("register reset too short");

  AST_HARD_WAIT: assert property (@(posedge mclk) disable iff (!reset_n)
    (state_ff == PRG_HRST && hard_s && cnt_ff >= 32'd1) |=>
      (state_ff == PRG_WAIT && cnt_ff >= CNTW'(CYC_HWAIT)))
    else $error("hard reset wait not started");

  AST_NO_ACCESS: assert property (@(posedge mclk) disable iff (!reset_n)
    (state_ff == PRG_WAIT && cnt_ff > 32'd1 && soft_s && hard_s) |=> !smi_access_ok)
    else $error("access allowed during hold-off");

  AST_SHORT_PIN: assert property (@(posedge mclk) disable iff (!reset_n)
    (s_pin_release and cnt_ff < CNTW'(CYC_SRST - 1) and hard_s) |=> viol_ff)
    else $error("short pin pulse not flagged");

  AST_CLK_SEL: assert property (@(posedge mclk) disable iff (!reset_n)
    cfg_ff.clk_out_156 |=> ##1 clock_output_khz == 32'h0002_625A || !cfg_ff.clk_out_156)
    else $error("clock output frequency wrong");

  AST_ACK_ONE: assert property (@(posedge mclk) disable iff (!reset_n)
    (avs_read || avs_write) |-> ##[0:1] !avs_waitrequest)
    else $error("bus answer late");

  AST_IDLE_OUT: assert property (@(posedge mclk) disable iff (!reset_n)
    (state_ff == PRG_WAIT && cnt_ff == 32'd1 && soft_s && hard_s) |=> smi_access_ok)
    else $error("hold-off did not end");

endmodule

`default_nettype wire

// ==== rtl/prg_defs.svh ====
// Offsets, field positions, reset values and timing counts of the reset access gate
`ifndef PRG_DEFS_SVH
`define PRG_DEFS_SVH

// Register word offsets (byte addresses)
`define PRG_CTRL_OFS      8'h00
`define PRG_STAT_OFS      8'h04
`define PRG_SOFTRST_OFS   8'h08
`define PRG_CFG_OFS       8'h0C

// Control register fields
`define PRG_CTRL_FAST_BIT 0
`define PRG_CTRL_LONG_BIT 1
`define PRG_CTRL_REF_BIT  2
`define PRG_CTRL_CLK_BIT  3
`define PRG_CTRL_RST      32'h0000_0000

// Status register fields
`define PRG_STAT_BUSY_BIT  0
`define PRG_STAT_SRC_LSB   1
`define PRG_STAT_VIOL_BIT  4

// Times as printed
`define PRG_T_HRST_NS      100
`define PRG_T_SRST_MS      4
`define PRG_T_SREG_NS      100
`define PRG_T_WAIT_FAST_US 4
`define PRG_T_WAIT_MED_US  300
`define PRG_T_WAIT_LONG_MS 200
`define PRG_T_HWAIT_MS     20
`define PRG_T_HWAIT_LNG_MS 220

// Clock rate of mclk
`define PRG_CLK_HZ         20000000

// Cycle counts at the mclk rate; least times round up
`define PRG_CYC_HRST  ((`PRG_T_HRST_NS * (`PRG_CLK_HZ / 1000000) + 999) / 1000)
`define PRG_CYC_SREG  ((`PRG_T_SREG_NS * (`PRG_CLK_HZ / 1000000) + 999) / 1000)
`define PRG_CYC_FAST  (`PRG_T_WAIT_FAST_US * (`PRG_CLK_HZ / 1000000))
`define PRG_CYC_MED   (`PRG_T_WAIT_MED_US * (`PRG_CLK_HZ / 1000000))
`define PRG_CYC_SRST  (`PRG_T_SRST_MS * (`PRG_CLK_HZ / 1000))
`define PRG_CYC_LONG  (`PRG_T_WAIT_LONG_MS * (`PRG_CLK_HZ / 1000))
`define PRG_CYC_HWAIT (`PRG_T_HWAIT_MS * (`PRG_CLK_HZ / 1000))
`define PRG_CYC_HWLNG (`PRG_T_HWAIT_LNG_MS * (`PRG_CLK_HZ / 1000))

`endif

// ==== rtl/prg_pkg.sv ====
// Types shared by the reset access gate
package prg_pkg;

  typedef enum logic [2:0]
  {
    PRG_IDLE  = 3'b000,
    PRG_HRST  = 3'b001,
    PRG_SPIN  = 3'b010,
    PRG_SREG  = 3'b011,
    PRG_WAIT  = 3'b100
  } prg_state_e;

  typedef enum logic [1:0]
  {
    PRG_SRC_NONE = 2'b00,
    PRG_SRC_HARD = 2'b01,
    PRG_SRC_PIN  = 2'b10,
    PRG_SRC_REG  = 2'b11
  } prg_src_e;

  typedef struct packed
  {
    logic fast_restart;
    logic long_wait;
    logic ref_is_125;
    logic clk_out_156;
  } prg_cfg_s;

  typedef struct packed
  {
    logic       busy;
    prg_src_e   source;
    logic       violation;
  } prg_stat_s;

endpackage

// ==== rtl/prg_sync.sv ====
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none

module prg_sync
  import prg_pkg::*;
#(
  parameter int          WIDTH    = 1,
  parameter logic [15:0] RST_VAL  = 16'h0000
)
(
  input  wire logic             mclk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] nxt_meta;
  logic [WIDTH-1:0] nxt_sync;

  always_comb
  begin
    nxt_meta = async_in;
    nxt_sync = meta_ff;
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      meta_ff <= RST_VAL[WIDTH-1:0];
      sync_ff <= RST_VAL[WIDTH-1:0];
    end
    else
    begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign sync_out = sync_ff;

endmodule

`default_nettype wire

// ==== rtl/prg_clock_output.sv ====
// Reports the selected clock output frequency and a tick of mclk divided by two
`timescale 1ns/1ps
`default_nettype none

module prg_clock_output
  import prg_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        sel_156,
  output logic      [31:0] clock_output_khz,
  output logic             clock_output_tick
);

  // Frequencies in kHz; the real output comes from the analogue PLL
  localparam logic [31:0] KHZ_125 = 32'h0001_E848;
  localparam logic [31:0] KHZ_156 = 32'h0002_625A;

  logic [31:0] khz_ff;
  logic [31:0] nxt_khz;
  logic        tick_ff;
  logic        nxt_tick;

  always_comb
  begin
    nxt_khz  = sel_156 ? KHZ_156 : KHZ_125;
    nxt_tick = ~tick_ff;
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      khz_ff  <= KHZ_125;
      tick_ff <= 1'b0;
    end
    else
    begin
      khz_ff  <= nxt_khz;
      tick_ff <= nxt_tick;
    end
  end

  assign clock_output_khz  = khz_ff;
  assign clock_output_tick = tick_ff;

endmodule

`default_nettype wire

// ==== dv/prg_smi_model.sv ====
// Management controller model that drives the soft reset pin
`timescale 1ns/1ps
`default_nettype none

module prg_smi_model
  import prg_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        pulse_req,
  input  wire logic [15:0] pulse_len,
  output logic             soft_reset_pin_n,
  output logic             busy
);
  logic [15:0] left_ff;

  // The bench chooses the low time; short values are asked for only to provoke a violation
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      left_ff <= 16'h0000;
    else if (pulse_req && left_ff == 16'h0000)
      left_ff <= pulse_len;
    else if (left_ff != 16'h0000)
      left_ff <= left_ff - 16'h0001;
  end

  assign soft_reset_pin_n = (left_ff == 16'h0000);
  assign busy             = (left_ff != 16'h0000);
endmodule

`default_nettype wire

// ==== dv/phy_reset_access_gate_tb_top.sv ====
// Self-checking bench for the reset access gate
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, e) \
  begin \
    total_checks++; \
    if ((a) !== (e)) \
    begin \
      n_mismatch++; \
      $display("mismatch at %0t: got %0h exp %0h", $time, (a), (e)); \
    end \
  end

module phy_reset_access_gate_tb_top;
  import prg_pkg::*;

  typedef struct { int src; int fast; int lng; int w; } prg_row_s;

  logic        mclk = 1'b0;
  logic        reset_n = 1'b0;
  logic        hard_reset_n = 1'b1;
  logic        pulse_req = 1'b0;
  logic [15:0] pulse_len = 16'h0014;
  logic        soft_reset_pin_n;
  logic        busy;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [1:0]  avs_response;
  logic        smi_access_ok;
  logic        phy_core_reset;
  logic [31:0] clock_output_khz;
  logic        clock_output_tick;
  logic [31:0] q;
  logic [1:0]  r;
  int          n_mismatch = 0;
  int          total_checks = 0;

  // Source 0 pin, 1 register, 2 hard reset; w is the shortened hold-off
  prg_row_s rows [8] = '{'{0, 1, 0, 5}, '{0, 0, 0, 30}, '{0, 0, 1, 200}, '{0, 1, 1, 200},
                         '{1, 1, 0, 5}, '{1, 0, 0, 30}, '{2, 0, 0, 50}, '{2, 0, 1, 60}};

  always #25 mclk = ~mclk;

  prg_gate #(.CYC_SRST(20), .CYC_LONG(200), .CYC_HWAIT(50), .CYC_HWLNG(60), .CYC_MED(30),
             .CYC_FAST(5)) prg_gate_i (
    .mclk(mclk), .reset_n(reset_n), .hard_reset_n(hard_reset_n),
    .soft_reset_pin_n(soft_reset_pin_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .smi_access_ok(smi_access_ok),
    .phy_core_reset(phy_core_reset), .clock_output_khz(clock_output_khz),
    .clock_output_tick(clock_output_tick));

  prg_smi_model prg_smi_model_i (
    .mclk(mclk), .reset_n(reset_n), .pulse_req(pulse_req), .pulse_len(pulse_len),
    .soft_reset_pin_n(soft_reset_pin_n), .busy(busy));

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Request stands until waitrequest is sampled low at a rising edge; the answer is taken there
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do
    begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    r = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0)
    begin
      n_mismatch++;
      test_done();
    end
    @(posedge mclk);
  endtask

  task automatic pulse(input logic [15:0] len);
    int n;
    n = 0;
    pulse_len <= len;
    pulse_req <= 1'b1;
    @(posedge mclk);
    pulse_req <= 1'b0;
    do
    begin
      @(negedge mclk);
      n++;
    end while (busy === 1'b1 && n < 100);
    if (busy !== 1'b0)
    begin
      n_mismatch++;
      test_done();
    end
    @(posedge mclk);
  endtask

  // Counts cycles from release until access is allowed again
  task automatic wait_ok(input int w);
    int c;
    c = 0;
    do
    begin
      @(negedge mclk);
      c++;
    end while (smi_access_ok !== 1'b1 && c < 400);
    `CHK(c >= w - 1 && c <= w + 7, 1'b1)
    if (c >= 400)
      test_done();
    @(posedge mclk);
  endtask

  initial
  begin
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    @(negedge mclk);
    `CHK(clock_output_khz, 32'h0001_E848)
    `CHK(smi_access_ok, 1'b1)
    `CHK(phy_core_reset, 1'b0)
    `CHK(clock_output_tick, 1'b0)
    @(negedge mclk);
    `CHK(clock_output_tick, 1'b1)
    @(posedge mclk);
    foreach (rows[i])
    begin
      bus(1'b1, 8'h00, 32'(rows[i].lng * 2 + rows[i].fast));
      if (rows[i].src == 0)
        pulse(16'h0014);
      else if (rows[i].src == 1)
        bus(1'b1, 8'h08, 32'h0000_8000);
      else
      begin
        hard_reset_n <= 1'b0;
        repeat (10) @(posedge mclk);
        hard_reset_n <= 1'b1;
      end
      wait_ok(rows[i].w);
      repeat (25) @(posedge mclk);
      $display("row %0d done", i);
    end
    bus(1'b1, 8'h00, 32'h0000_0008);
    @(negedge mclk);
    `CHK(clock_output_khz, 32'h0002_625A)
    @(posedge mclk);
    // A write with the low byte disabled must leave the control bits alone
    avs_byteenable <= 4'hE;
    bus(1'b1, 8'h00, 32'h0000_0000);
    avs_byteenable <= 4'hF;
    bus(1'b0, 8'h00, 32'h0);
    `CHK(q, 32'h0000_0008)
    $display("clock output select done");
    // Pulses of exactly the minimum length leave the flag clear; last source was hard reset
    bus(1'b0, 8'h04, 32'h0);
    `CHK(r, 2'b00)
    `CHK(q, 32'h0000_0002)
    // The flag is cleared by writing one, then a pulse shorter than the minimum must set it
    bus(1'b1, 8'h04, 32'h0000_0010);
    bus(1'b0, 8'h04, 32'h0);
    `CHK(q[4], 1'b0)
    pulse(16'h0005);
    wait_ok(30);
    bus(1'b0, 8'h04, 32'h0);
    `CHK(q[4], 1'b1)
    $display("short pulse done");
    // Second pulse follows the first within the minimum gap
    bus(1'b1, 8'h04, 32'h0000_0010);
    bus(1'b1, 8'h00, 32'h0000_0001);
    pulse(16'h0014);
    pulse(16'h0014);
    wait_ok(5);
    bus(1'b0, 8'h04, 32'h0);
    `CHK(q[4], 1'b1)
    $display("short gap done");
    bus(1'b0, 8'h40, 32'h0);
    `CHK(r, 2'b10)
    `CHK(q, 32'h0000_0000)
    $display("unmapped read done");
    // Reset in the middle of a pin sequence reopens access with defaults
    pulse(16'h0014);
    reset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    @(negedge mclk);
    `CHK(smi_access_ok, 1'b1)
    `CHK(phy_core_reset, 1'b0)
    `CHK(clock_output_khz, 32'h0001_E848)
    @(posedge mclk);
    bus(1'b0, 8'h00, 32'h0);
    `CHK(q, 32'h0000_0000)
    $display("mid-run reset done");
    test_done();
  end
endmodule

`default_nettype wire
